// [rtl/xsh_pkg.sv]
package xsh_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned SAMPLE_HZ       = 128_000;
    localparam int unsigned SAMPLE_DIV      = CLK_HZ / SAMPLE_HZ;      // 312 system clocks per sample tick
    localparam int unsigned BG_TIME_MS      = 1000;                    // background gather time
    localparam int unsigned BG_TICKS        = SAMPLE_HZ / 1000 * BG_TIME_MS;

    // geometry
    localparam int unsigned SEG_COUNT       = 32;
    localparam int unsigned SEG_BITS        = 5;
    localparam int unsigned CHAN_BITS       = 4;
    localparam int unsigned ADDR_BITS       = 9;
    localparam int unsigned WORD_BITS       = 8;
    localparam int unsigned MEM_WORDS       = 512;
    localparam int unsigned PERIOD_BITS     = 20;
    localparam logic [4:0]  SWEEPS_VERT     = 5'h1b;                   // 27 fan beams
    localparam logic [4:0]  SWEEPS_SLANT    = 5'h0d;                   // 13 fan beams
    localparam logic [4:0]  LAST_SEG        = 5'h1f;                   // segment 32 is dropped
    localparam logic [4:0]  LEAD_PULSES     = 5'h02;                   // pulses -15 then -14, which opens timing
    localparam logic [3:0]  REJECT_CHAN     = 4'h0;                    // channel 1 of 16
    localparam logic [1:0]  PASS_CYCLE_LAST = 2'h3;

    // systems
    typedef enum logic [1:0]
    {
        XSH_SYS_VERT   = 2'h0,
        XSH_SYS_SLANTA = 2'h1,
        XSH_SYS_SLANTB = 2'h2
    } xsh_sys_t;

    // one analysed event from the amplitude digitizer
    typedef struct packed
    {
        logic                 valid;
        logic [CHAN_BITS-1:0] chan;
        logic                 rejected;
        logic [1:0]           det_sys;
    } xsh_event_t;

    // readout request and answer
    typedef struct packed
    {
        logic                 rd_en;
        logic [ADDR_BITS-1:0] addr;
    } xsh_rdreq_t;

    typedef struct packed
    {
        logic                 valid;
        logic [WORD_BITS-1:0] data;
    } xsh_rddat_t;

endpackage

// [rtl/xsh_hist_mem.sv]
`timescale 1ns/1ps
// one 512 x 8 histogram memory with increment and read port
module xsh_hist_mem
    import xsh_pkg::*;
(
    input  wire logic                 i_clock,   // system clock
    input  wire logic                 i_inc,     // add one at inc address
    input  wire logic [ADDR_BITS-1:0] i_inc_addr,// segment and channel
    input  wire logic                 i_rd,      // readout strobe
    input  wire logic                 i_clear,   // zero word after read
    input  wire logic [ADDR_BITS-1:0] i_rd_addr, // readout address
    output logic      [WORD_BITS-1:0] o_rd_data  // word one cycle after strobe
);
    logic [WORD_BITS-1:0] mem [MEM_WORDS];

    // read-modify-write increment; readout clears for the next gather
    always_ff @(posedge i_clock)
    begin
        if (i_inc)
        begin
            mem[i_inc_addr] <= mem[i_inc_addr] + 8'h01;
        end
        if (i_rd)
        begin
            o_rd_data <= mem[i_rd_addr];
            if (i_clear)
            begin
                mem[i_rd_addr] <= '0;
            end
        end
    end
endmodule

// [rtl/xsh_gather.sv]
`timescale 1ns/1ps
module xsh_gather
    import xsh_pkg::*;
(
    input  wire logic                 i_clock,        // 40 MHz
    input  wire logic                 i_rst_n,        // async reset, active low
    input  wire logic                 i_trigger,      // trigger eye pulse level
    input  wire logic [7:0]           i_sun_level,    // optical detector sample
    input  wire logic                 i_event_valid,  // digitizer event strobe level
    input  wire logic [CHAN_BITS-1:0] i_event_chan,   // amplitude_digitizer channel
    input  wire logic                 i_event_reject, // rise_shape_rejector flag
    input  wire logic [1:0]           i_event_sys,    // detector's system
    input  wire logic                 i_pass_end,     // wheel passed sun, start new pass
    input  wire logic                 i_antisun,      // wheel faces away from sun
    input  wire logic                 i_rd_en,        // readout strobe
    input  wire logic [ADDR_BITS-1:0] i_rd_addr,      // readout address
    output logic                      o_rd_valid,     // readout data valid
    output logic      [WORD_BITS-1:0] o_rd_data,      // readout word
    output logic                      o_rd_slant,     // memory being read is slant one
    output logic                      o_gathering,    // solar gather window open
    output logic                      o_background,   // background gather active
    output logic      [SEG_BITS-1:0]  o_segment,      // current segment
    output logic      [PERIOD_BITS-1:0] o_period      // last period count
);
    typedef enum logic [3:0]
    {
        ST_IDLE   = 4'b0001,
        ST_LEAD   = 4'b0010,
        ST_DELAY  = 4'b0100,
        ST_TRAV   = 4'b1000
    } xsh_state_t;

    typedef struct packed
    {
        xsh_state_t             st;
        logic [8:0]             div;       // sample tick divider
        logic [PERIOD_BITS-1:0] cnt;       // ticks since last sun pulse
        logic [PERIOD_BITS-1:0] period;
        logic [PERIOD_BITS-1:0] win;       // ticks into traversal, held at zero in delay
        logic [SEG_BITS-1:0]    seg;
        logic [PERIOD_BITS-1:0] seg_cnt;
        logic [4:0]             pulses;
        logic [4:0]             sweeps;
        logic [7:0]             prev_lvl;
        logic                   rising;
        logic [1:0]             pass_idx;  // pass within four-pass cycle
        logic [19:0]            bg_cnt;
        logic                   bg;
        logic                   trig_d;
        logic                   ev_d;
        logic                   rd_v;
        logic                   rd_slant;
        logic [PERIOD_BITS-1:0] dly;       // ticks since the last beam's sun pulse
        logic                   dly_on;
        logic                   wipe;      // clearing both memories after reset
        logic [ADDR_BITS-1:0]   wipe_addr;
    } xsh_regs_t;

    xsh_regs_t r_q, r_d;
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [1:0] trig_s_q, ev_s_q;
    logic [7:0] lvl_s1_q, lvl_s2_q;
    xsh_event_t ev_s1_q, ev_s2_q;
    logic pass_s1_q, pass_s2_q, anti_s1_q, anti_s2_q;
    logic pass_d_q;
    logic tick, sun_pulse, trig_pulse, ev_pulse;
    logic vert_active, slant_a, slant_b;
    logic inc_v, inc_s;
    logic [ADDR_BITS-1:0] inc_addr;
    logic [WORD_BITS-1:0] rd_v_data, rd_s_data;

    // reset release through two flip-flops
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // two-stage synchronisers for every pin input except the readout strobe and address
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_s_q  <= 2'h0;
            ev_s_q    <= 2'h0;
            lvl_s1_q  <= 8'h00;
            lvl_s2_q  <= 8'h00;
            ev_s1_q   <= '0;
            ev_s2_q   <= '0;
            pass_s1_q <= 1'b0;
            pass_s2_q <= 1'b0;
            anti_s1_q <= 1'b0;
            anti_s2_q <= 1'b0;
            pass_d_q  <= 1'b0;
        end
        else
        begin
            trig_s_q  <= {trig_s_q[0], i_trigger};
            ev_s_q    <= {ev_s_q[0], i_event_valid};
            lvl_s1_q  <= i_sun_level;
            lvl_s2_q  <= lvl_s1_q;
            ev_s1_q   <= {i_event_valid, i_event_chan, i_event_reject, i_event_sys};
            ev_s2_q   <= ev_s1_q;
            pass_s1_q <= i_pass_end;
            pass_s2_q <= pass_s1_q;
            anti_s1_q <= i_antisun;
            anti_s2_q <= anti_s1_q;
            pass_d_q  <= pass_s2_q;
        end
    end

    // pass schedule: vertical always, slant a on passes 0-1, slant b on 2-3
    assign vert_active = 1'b1;
    assign slant_a     = (r_q.pass_idx[1] == 1'b0);
    assign slant_b     = (r_q.pass_idx[1] == 1'b1);

    // edge and peak detection
    assign tick       = (r_q.div == 9'(SAMPLE_DIV - 1));
    assign trig_pulse = trig_s_q[1] & ~r_q.trig_d;
    assign sun_pulse  = tick & r_q.rising & (lvl_s2_q < r_q.prev_lvl);
    assign ev_pulse   = ev_s_q[1] & ~r_q.ev_d;

    // next-state logic
    always_comb
    begin
        r_d        = r_q;
        r_d.trig_d = trig_s_q[1];
        r_d.ev_d   = ev_s_q[1];
        r_d.rd_v   = i_rd_en;
        r_d.div    = tick ? 9'h000 : r_q.div + 9'h001;
        r_d.wipe_addr = r_q.wipe_addr + 9'(r_q.wipe);           // memories have no reset: zero them once
        r_d.wipe      = r_q.wipe && (r_q.wipe_addr != 9'h1ff);
        if (tick)
        begin
            r_d.prev_lvl = lvl_s2_q;
            if (lvl_s2_q > r_q.prev_lvl)
                r_d.rising = 1'b1;
            else if (lvl_s2_q < r_q.prev_lvl)
                r_d.rising = 1'b0;
            r_d.cnt = r_q.cnt + 20'h00001;
        end
        if (sun_pulse)
        begin
            r_d.period = r_q.cnt;
            r_d.cnt    = 20'h00001;                             // the pulse's own tick counts
        end
        unique case (r_q.st)
            ST_IDLE:
            begin
                if (trig_pulse)
                begin
                    r_d.st     = ST_LEAD;
                    r_d.pulses = 5'h00;
                    r_d.sweeps = 5'h00;
                end
            end
            ST_LEAD:
            begin
                if (sun_pulse)
                begin
                    r_d.pulses = r_q.pulses + 5'h01;
                    if (r_q.pulses == LEAD_PULSES - 5'h01)
                        r_d.st = ST_DELAY;
                end
            end
            ST_DELAY: r_d.win = '0;                             // traversal opens from the beam delay timer
            ST_TRAV:
            begin
                if (tick)
                begin
                    r_d.win     = r_q.win + 20'h00001;
                    r_d.seg_cnt = r_q.seg_cnt + 20'h00001;
                    if (r_q.seg_cnt + 20'h00001 >= (r_q.period >> 5))
                    begin
                        r_d.seg_cnt = '0;
                        if (r_q.seg != LAST_SEG)
                            r_d.seg = r_q.seg + 5'h01;
                    end
                    if (r_q.win + 20'h00001 >= r_q.period)
                    begin
                        r_d.sweeps = r_q.sweeps + 5'h01;
                        r_d.win    = '0;
                        r_d.st     = (r_q.sweeps + 5'h01 >= SWEEPS_VERT) ? ST_IDLE : ST_DELAY;
                    end
                end
            end
        endcase
        // beam delay: the last lead pulse and every sun pulse in delay or traversal restart it, half a period later a traversal opens
        if (sun_pulse && (r_q.st == ST_DELAY || r_q.st == ST_TRAV || r_d.st == ST_DELAY))
        begin
            r_d.dly_on = 1'b1;
            r_d.dly    = '0;
        end
        else if (r_q.dly_on && tick)
        begin
            r_d.dly    = r_q.dly + 20'h00001;
            r_d.dly_on = (r_q.dly + 20'h00001 < (r_q.period >> 1));
        end
        if (r_q.dly_on && !r_d.dly_on && (r_d.st == ST_DELAY || r_d.st == ST_TRAV))
        begin
            r_d.st      = ST_TRAV;
            r_d.win     = '0;
            r_d.seg     = '0;
            r_d.seg_cnt = '0;
        end
        // pass bookkeeping; reading alternates vertical/slant memory
        if (pass_s2_q && !pass_d_q)
        begin
            r_d.pass_idx = r_q.pass_idx + 2'h1;
            if (r_q.pass_idx[0])
                r_d.rd_slant = ~r_q.rd_slant;
            r_d.st = ST_IDLE;
            r_d.dly_on = 1'b0;
        end
        // background window in anti-sun direction, about one second
        if (anti_s2_q && !r_q.bg && r_q.bg_cnt == '0)
        begin
            r_d.bg     = 1'b1;
            r_d.bg_cnt = 20'(BG_TICKS);
        end
        else if (r_q.bg && tick)
        begin
            r_d.bg_cnt = r_q.bg_cnt - 20'h00001;
            if (r_q.bg_cnt == 20'h00001)
                r_d.bg = 1'b0;
        end
        if (!anti_s2_q && !r_q.bg)
            r_d.bg_cnt = '0;
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q        <= '0;
            r_q.st     <= ST_IDLE;
            r_q.wipe   <= 1'b1;
        end
        else
            r_q <= r_d;
    end

    // event routing: gated detector in traversal, any detector in background; rejected events to channel 1
    logic acc_ok, sys_gathers;
    logic [CHAN_BITS-1:0] chan;
    always_comb
    begin
        chan        = ev_s2_q.rejected ? REJECT_CHAN : ev_s2_q.chan;
        inc_addr    = {r_q.seg, chan};
        acc_ok      = ev_pulse && r_q.st == ST_TRAV && r_q.seg != LAST_SEG;
        sys_gathers = 1'b0;
        if (ev_s2_q.det_sys == XSH_SYS_VERT)
            sys_gathers = vert_active;
        else if (ev_s2_q.det_sys == XSH_SYS_SLANTA)
            sys_gathers = slant_a && r_q.sweeps < SWEEPS_SLANT;
        else if (ev_s2_q.det_sys == XSH_SYS_SLANTB)
            sys_gathers = slant_b && r_q.sweeps < SWEEPS_SLANT;
        inc_v = 1'b0;
        inc_s = 1'b0;
        if (acc_ok && sys_gathers)
        begin
            inc_v = ev_s2_q.det_sys == XSH_SYS_VERT;
            inc_s = ev_s2_q.det_sys != XSH_SYS_VERT;
        end
        else if (ev_pulse && r_q.bg)
        begin
            inc_v = r_q.rd_slant;                                      // next to read
            inc_s = ~r_q.rd_slant;
        end
    end

    // the two accumulation memories
    xsh_hist_mem u_mem_vert
    (
        .i_clock    (i_clock),
        .i_inc      (inc_v),
        .i_inc_addr (inc_addr),
        .i_rd       (r_q.wipe || (i_rd_en && !r_q.rd_slant)),
        .i_clear    (1'b1),
        .i_rd_addr  (r_q.wipe ? r_q.wipe_addr : i_rd_addr),
        .o_rd_data  (rd_v_data)
    );
    xsh_hist_mem u_mem_slant
    (
        .i_clock    (i_clock),
        .i_inc      (inc_s),
        .i_inc_addr (inc_addr),
        .i_rd       (r_q.wipe || (i_rd_en && r_q.rd_slant)),
        .i_clear    (1'b1),
        .i_rd_addr  (r_q.wipe ? r_q.wipe_addr : i_rd_addr),
        .o_rd_data  (rd_s_data)
    );

    // registered outputs
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_rd_valid   <= 1'b0;
            o_rd_data    <= 8'h00;
            o_rd_slant   <= 1'b0;
            o_gathering  <= 1'b0;
            o_background <= 1'b0;
            o_segment    <= 5'h00;
            o_period     <= '0;
        end
        else
        begin
            o_rd_valid   <= r_q.rd_v;
            o_rd_data    <= r_q.rd_slant ? rd_s_data : rd_v_data;
            o_rd_slant   <= r_q.rd_slant;
            o_gathering  <= (r_q.st == ST_TRAV);
            o_background <= r_q.bg;
            o_segment    <= r_q.seg;
            o_period     <= r_q.period;
        end
    end

    // checks
    a_seg_drop: assert property (@(posedge i_clock) disable iff (!rst_n)
        (r_q.seg == LAST_SEG) |-> !((inc_v || inc_s) && !r_q.bg))
        else $error("event stored in segment 32");
    a_period_upd: assert property (@(posedge i_clock) disable iff (!rst_n)
        sun_pulse |=> (r_q.period == $past(r_q.cnt)))
        else $error("period not captured");
    a_addr_join: assert property (@(posedge i_clock) disable iff (!rst_n)
        (inc_v || inc_s) |-> inc_addr[8:4] == r_q.seg)
        else $error("address segment mismatch");
    a_reject_chan: assert property (@(posedge i_clock) disable iff (!rst_n)
        ev_s2_q.rejected |-> inc_addr[3:0] == REJECT_CHAN)
        else $error("rejected event not in channel 1");
    a_one_mem: assert property (@(posedge i_clock) disable iff (!rst_n)
        !(inc_v && inc_s))
        else $error("both memories incremented");
    a_sweep_max: assert property (@(posedge i_clock) disable iff (!rst_n)
        r_q.sweeps <= SWEEPS_VERT)
        else $error("too many sweeps");
    a_trav_first: assert property (@(posedge i_clock) disable iff (!rst_n)
        (r_q.st == ST_DELAY) ##1 (r_q.st == ST_TRAV) |-> r_q.seg == 5'h00)
        else $error("traversal not starting at segment 0");
    a_gate_trav: assert property (@(posedge i_clock) disable iff (!rst_n)
        ((inc_v || inc_s) && !r_q.bg) |-> r_q.st == ST_TRAV)
        else $error("solar event outside traversal");
endmodule

// [verification/xsh_sky_model.sv]
`timescale 1ns/1ps
// sun-facing optics: a trigger eye pulse, then one sun-level peak per fan beam
module xsh_sky_model
    import xsh_pkg::*;
#(
    parameter int PERIOD = 32,  // sample ticks between sun-centre peaks
    parameter int BEAMS  = 2    // fan beams timed per pass
)
(
    input  wire logic       i_clock,     // system clock
    input  wire logic       i_start,     // begin one solar pass
    output logic            o_trigger,   // trigger eye level
    output logic [7:0]      o_sun_level  // optical detector sample
);
    localparam int FIRST = PERIOD / 2 + 4;  // peak of beam -15

    int div;
    int tick;
    bit run;
    int r;

    // dark and quiet until a pass starts
    initial
    begin
        o_trigger = 1'b0;
        o_sun_level = 8'h00;
    end

    // sample-rate tick count while the sun is in view; peaks every PERIOD ticks
    always @(posedge i_clock)
    begin
        if (i_start)
        begin
            run = 1'b1;
            tick = 0;
            div = 0;
        end
        else if (run)
        begin
            div = (div + 1) % SAMPLE_DIV;
            if (div == 0)
                tick = tick + 1;
            if (tick > FIRST + PERIOD * BEAMS + PERIOD / 2)
                run = 1'b0;
        end
        r = (tick - FIRST + 4 * PERIOD) % PERIOD;
        r = (r > PERIOD / 2) ? PERIOD - r : r;
        o_trigger <= #1 run && tick < 2;
        o_sun_level <= #1 (run && tick >= 4) ? 8'(200 - 6 * r) : 8'h00;
    end
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
// two solar passes of timed fan beams with random events, then full readback
module tb_top
    import xsh_pkg::*;
;
    localparam int PERIOD   = 32;                       // sun pulse spacing in ticks
    localparam int BEAMS    = 2;                        // fan beams per pass
    localparam int SEG_CLKS = SAMPLE_DIV * (PERIOD / 32);

    logic                   i_clock, i_rst_n, i_event_valid, i_event_reject, i_pass_end, i_antisun;
    logic                   i_rd_en, i_trigger, o_rd_valid, o_rd_slant, o_gathering, o_background, sky_start;
    logic [7:0]             i_sun_level;
    logic [CHAN_BITS-1:0]   i_event_chan;
    logic [1:0]             i_event_sys;
    logic [ADDR_BITS-1:0]   i_rd_addr;
    logic [WORD_BITS-1:0]   o_rd_data;
    logic [SEG_BITS-1:0]    o_segment;
    logic [PERIOD_BITS-1:0] o_period;
    int                     failures, check_count, seed, n;
    int                     mem [2][MEM_WORDS];         // expected words, vertical then slant

    xsh_gather xsh_gather_i
    (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_trigger(i_trigger), .i_sun_level(i_sun_level),
        .i_event_valid(i_event_valid), .i_event_chan(i_event_chan), .i_event_reject(i_event_reject),
        .i_event_sys(i_event_sys), .i_pass_end(i_pass_end), .i_antisun(i_antisun), .i_rd_en(i_rd_en),
        .i_rd_addr(i_rd_addr), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_slant(o_rd_slant),
        .o_gathering(o_gathering), .o_background(o_background), .o_segment(o_segment), .o_period(o_period)
    );

    xsh_sky_model #(.PERIOD(PERIOD), .BEAMS(BEAMS)) xsh_sky_model_i
    (
        .i_clock(i_clock), .i_start(sky_start), .o_trigger(i_trigger), .o_sun_level(i_sun_level)
    );

    // 40 MHz clock
    initial
    begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // count a comparison and report a mismatch at once
    task automatic judge(input logic ok, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (!ok)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        judge(got === exp, 32'(got), 32'(exp));
    endtask
    task automatic chk_word(input logic [WORD_BITS-1:0] got, input logic [WORD_BITS-1:0] exp);
        judge(got === exp, 32'(got), 32'(exp));
    endtask
    task automatic chk_seg(input logic [SEG_BITS-1:0] got, input logic [SEG_BITS-1:0] exp);
        judge(got === exp, 32'(got), 32'(exp));
    endtask
    task automatic chk_count(input logic [PERIOD_BITS-1:0] got, input logic [PERIOD_BITS-1:0] exp);
        judge(got === exp, 32'(got), 32'(exp));
    endtask

    task automatic tick;
        @(posedge i_clock);
        #1;
    endtask

    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one random event held steady around its strobe edge, about 100 clocks into its segment
    task automatic inject(input int seg, input int beam);
        logic [1:0] sys;
        logic [3:0] ch;
        logic       rej;
        sys = 2'($unsigned($random(seed)) % 3);
        ch = {beam[0], 3'($random(seed))};
        rej = ($random(seed) & 7) == 0;
        i_event_sys = sys;
        i_event_chan = ch;
        i_event_reject = rej;
        repeat (100) tick;
        i_event_valid = 1'b1;
        repeat (8) tick;
        i_event_valid = 1'b0;
        repeat (8) tick;
        if (seg != 31 && sys != 2'h2)
            mem[sys != 2'h0][{5'(seg), rej ? REJECT_CHAN : ch}]++;
    endtask

    // one pass-end pulse on the pin, long enough for its synchroniser
    task automatic end_pass;
        i_pass_end = 1'b1;
        repeat (4) tick;
        i_pass_end = 1'b0;
        repeat (16) tick;
    endtask

    // trigger, beams with an event per segment, then end of pass
    task automatic run_pass(input int pass);
        int k;
        tick;
        sky_start = 1'b1;
        tick;
        sky_start = 1'b0;
        n = 0;
        while (o_gathering !== 1'b1 && n < 60000)
        begin
            tick;
            n++;
        end
        chk_count(o_period, 20'(PERIOD));
        for (k = 0; k < 32 * BEAMS; k++)
        begin
            chk_seg(o_segment, 5'(k));
            chk_bit(o_gathering, 1'b1);
            n = 116;
            inject(k % 32, k / 32);
            while (k < 32 * BEAMS - 1 && o_segment === 5'(k) && n < 1000)
            begin
                tick;
                n++;
            end
            if (k < 32 * BEAMS - 1)
                chk_count(20'(n), 20'(SEG_CLKS));
        end
        end_pass;
        $display("pass %0d done", pass);
    endtask

    // read every word twice: totals first, cleared words after
    task automatic read_back;
        int   r;
        int   a;
        logic sel;
        for (r = 0; r < 2; r++)
            for (a = 0; a < MEM_WORDS; a++)
            begin
                sel = o_rd_slant;
                i_rd_addr = 9'(a);
                i_rd_en = 1'b1;
                tick;
                i_rd_en = 1'b0;
                tick;
                chk_bit(o_rd_valid, 1'b1);
                chk_word(o_rd_data, 8'(mem[sel][a]));
                mem[sel][a] = 0;
            end
    endtask

    // main sequence
    initial
    begin
        seed = 90793;
        failures = 0;
        check_count = 0;
        i_rst_n = 1'b0;
        i_event_valid = 1'b0;
        i_event_reject = 1'b0;
        i_event_chan = 4'h0;
        i_event_sys = 2'h0;
        i_pass_end = 1'b0;
        i_antisun = 1'b0;
        i_rd_en = 1'b0;
        i_rd_addr = 9'h000;
        sky_start = 1'b0;
        repeat (5) tick;
        i_rst_n = 1'b1;
        repeat (3) tick;
        chk_bit(o_gathering, 1'b0);
        chk_bit(o_rd_valid, 1'b0);
        chk_count(o_period, 20'h00000);
        $display("reset test done");
        run_pass(0);
        run_pass(1);
        chk_bit(o_rd_slant, 1'b1);
        read_back;
        end_pass;
        end_pass;
        chk_bit(o_rd_slant, 1'b0);
        read_back;
        $display("readback test done");
        chk_bit(o_background, 1'b0);
        i_antisun = 1'b1;
        repeat (8) tick;
        chk_bit(o_background, 1'b1);
        $display("background test done");
        report_and_stop;
    end

    // hang guard, a margin over the expected run of about 88,000 cycles
    initial
    begin
        #(100000 * 25);
        failures++;
        report_and_stop;
    end
endmodule
